// ==== supervisor_fault_status_flags.sv ====
`timescale 1ns/1ns
module supervisor_fault_status_flags
   import fault_status_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // Register port from the serial interface
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // Interrupt enables
   input  wire logic       runtime_check_enable_i,
   input  wire logic       thermal_shutdown_enable_i,
   input  wire logic       packet_check_enable_i,
   input  wire logic       single_error_enable_i,
   input  wire logic       self_test_done_enable_i,
   input  wire logic       self_test_fail_enable_i,
   input  wire logic       require_packet_code_i,
   // Fault events from on-chip logic, one-cycle pulses
   input  wire logic       crc_mismatch_i,
   input  wire logic       packet_code_mismatch_i,
   input  wire logic       packet_code_missing_i,
   input  wire logic       single_error_i,
   input  wire logic       double_error_i,
   input  wire logic       self_test_done_i,
   input  wire logic       self_test_fail_i,
   // Fault conditions from analog detectors, asynchronous levels
   input  wire logic       irq_pin_fault_i,
   input  wire logic       thermal_shutdown_i,
   // Status outputs
   output logic      [7:0] control_comm_fault_status_o,
   output logic      [7:0] test_config_load_fault_status_o,
   output logic            failsafe_o
);

   logic [1:0]           irq_sync_q;
   logic [1:0]           therm_sync_q;
   logic                 irq_lvl;
   logic                 therm_lvl;
   logic                 wr_ctl;
   logic                 wr_tst;
   logic [NUM_FLAGS-1:0] set_v;
   logic [NUM_FLAGS-1:0] clr_v;
   logic [NUM_FLAGS-1:0] hold_v;
   logic [NUM_FLAGS-1:0] flag_v;
   logic [7:0]           ctl_d;
   logic [7:0]           tst_d;
   logic [7:0]           ctl_q;
   logic [7:0]           tst_q;
   logic [7:0]           rdata_q;
   logic                 failsafe_q;
   logic [7:0]           ctl_img;
   logic [7:0]           tst_img;

   // Flag slots in the cell array: control flags first, then test flags
   localparam int SLOT_CRC    = 0;
   localparam int SLOT_PIN    = 1;
   localparam int SLOT_THERM  = 2;
   localparam int SLOT_PKT    = 3;
   localparam int SLOT_SINGLE = 4;
   localparam int SLOT_DOUBLE = 5;
   localparam int SLOT_DONE   = 6;
   localparam int SLOT_FAIL   = 7;

   // Address match, shared by both write decodes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction : hit

   // Two-stage synchronisers for the analog fault levels
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_sync_q   <= '0;
         therm_sync_q <= '0;
      end else begin
         irq_sync_q   <= {irq_sync_q[0], irq_pin_fault_i};
         therm_sync_q <= {therm_sync_q[0], thermal_shutdown_i};
      end
   end

   assign irq_lvl   = irq_sync_q[1];
   assign therm_lvl = therm_sync_q[1];

   // Write decode
   assign wr_ctl = reg_wr_i &&
                   hit(reg_addr_i, CONTROL_COMM_FAULT_STATUS_ADDR);
   assign wr_tst = reg_wr_i &&
                   hit(reg_addr_i, TEST_CONFIG_LOAD_FAULT_STATUS_ADDR);

   // Set terms; control flags in slots 0..3, test flags in 4..7
   always_comb begin
      set_v              = '0;
      set_v[SLOT_CRC]    = crc_mismatch_i && runtime_check_enable_i;
      set_v[SLOT_PIN]    = irq_lvl;
      set_v[SLOT_THERM]  = therm_lvl && thermal_shutdown_enable_i;
      set_v[SLOT_PKT]    = packet_check_enable_i &&
         (packet_code_mismatch_i ||
          (require_packet_code_i && packet_code_missing_i));
      set_v[SLOT_SINGLE] = single_error_i && single_error_enable_i;
      set_v[SLOT_DOUBLE] = double_error_i;
      set_v[SLOT_DONE]   = self_test_done_i && self_test_done_enable_i;
      set_v[SLOT_FAIL]   = self_test_fail_i && self_test_fail_enable_i;
   end

   // Clear terms: only bits written as one are cleared
   always_comb begin
      clr_v              = '0;
      clr_v[SLOT_CRC]    = wr_ctl && reg_wdata_i[CRC_FAULT_BIT];
      clr_v[SLOT_PIN]    = wr_ctl && reg_wdata_i[IRQ_PIN_FAULT_BIT];
      clr_v[SLOT_THERM]  = wr_ctl && reg_wdata_i[THERMAL_FAULT_BIT];
      clr_v[SLOT_PKT]    = wr_ctl && reg_wdata_i[PACKET_ERROR_BIT];
      clr_v[SLOT_SINGLE] = wr_tst && reg_wdata_i[SEC_BIT];
      clr_v[SLOT_DOUBLE] = wr_tst && reg_wdata_i[DED_BIT];
      clr_v[SLOT_DONE]   = wr_tst && reg_wdata_i[SELF_TEST_DONE_BIT];
      clr_v[SLOT_FAIL]   = wr_tst && reg_wdata_i[SELF_TEST_FAIL_BIT];
   end

   // Condition-held flags resist a clear while the fault is present
   always_comb begin
      hold_v             = '0;
      hold_v[SLOT_PIN]   = irq_lvl;
      hold_v[SLOT_THERM] = therm_lvl;
   end

   // Sticky flag cells
   generate
      for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
         sticky_flag u_flag (
            .clk_i   (clk_i),
            .nrst_i  (nrst_i),
            .set_i   (set_v[i]),
            .clear_i (clr_v[i]),
            .hold_i  (hold_v[i]),
            .flag_o  (flag_v[i])
         );
      end
   endgenerate

   // Register images; reserved bits stay zero
   always_comb begin
      ctl_d                    = STATUS_RESET;
      ctl_d[CRC_FAULT_BIT]      = flag_v[SLOT_CRC];
      ctl_d[IRQ_PIN_FAULT_BIT]  = flag_v[SLOT_PIN];
      ctl_d[THERMAL_FAULT_BIT]  = flag_v[SLOT_THERM];
      ctl_d[PACKET_ERROR_BIT]   = flag_v[SLOT_PKT];
      tst_d                     = STATUS_RESET;
      tst_d[SEC_BIT]            = flag_v[SLOT_SINGLE];
      tst_d[DED_BIT]            = flag_v[SLOT_DOUBLE];
      tst_d[SELF_TEST_DONE_BIT] = flag_v[SLOT_DONE];
      tst_d[SELF_TEST_FAIL_BIT] = flag_v[SLOT_FAIL];
   end

   // Masked images shared by the status outputs and the read path
   assign ctl_img = ctl_d & CONTROL_MASK;
   assign tst_img = tst_d & TEST_MASK;

   // Registered control status output
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctl_q <= STATUS_RESET;
      end else begin
         ctl_q <= ctl_img;
      end
   end

   // Registered test status output
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tst_q <= STATUS_RESET;
      end else begin
         tst_q <= tst_img;
      end
   end

   // Read data, registered; unmapped addresses read as zero
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_q <= STATUS_RESET;
      end else if (reg_rd_i) begin
         if (hit(reg_addr_i, CONTROL_COMM_FAULT_STATUS_ADDR)) begin
            rdata_q <= ctl_img;
         end else if (hit(reg_addr_i,
                          TEST_CONFIG_LOAD_FAULT_STATUS_ADDR)) begin
            rdata_q <= tst_img;
         end else begin
            rdata_q <= STATUS_RESET;
         end
      end
   end

   // Failsafe latches on a double error and holds until reset
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         failsafe_q <= 1'b0;
      end else if (double_error_i) begin
         failsafe_q <= 1'b1;
      end
   end

   assign reg_rdata_o                     = rdata_q;
   assign control_comm_fault_status_o     = ctl_q;
   assign test_config_load_fault_status_o = tst_q;
   assign failsafe_o                      = failsafe_q;

endmodule : supervisor_fault_status_flags

// ==== fault_status_pkg.sv ====
package fault_status_pkg;

   // Register offsets and reset values
   localparam logic [7:0] CONTROL_COMM_FAULT_STATUS_ADDR     = 8'h22;
   localparam logic [7:0] TEST_CONFIG_LOAD_FAULT_STATUS_ADDR = 8'h23;
   localparam logic [7:0] STATUS_RESET                       = 8'h00;

   // Control and communication register bits
   localparam int CRC_FAULT_BIT      = 4;
   localparam int IRQ_PIN_FAULT_BIT  = 3;
   localparam int THERMAL_FAULT_BIT  = 2;
   localparam int PACKET_ERROR_BIT   = 0;

   // Test and configuration-load register bits
   localparam int SEC_BIT            = 3;
   localparam int DED_BIT            = 2;
   localparam int SELF_TEST_DONE_BIT = 1;
   localparam int SELF_TEST_FAIL_BIT = 0;

   // Readable bit masks; reserved bits read as zero
   localparam logic [7:0] CONTROL_MASK = 8'h1d;
   localparam logic [7:0] TEST_MASK    = 8'h0f;

   // Number of sticky flags handled by the cell array
   localparam int NUM_FLAGS = 8;

endpackage : fault_status_pkg

// ==== sticky_flag.sv ====
`timescale 1ns/1ns
// One write-1-to-clear sticky flag; a set in the clear cycle wins
module sticky_flag (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic nrst_i,
   // Control
   input  wire logic set_i,
   input  wire logic clear_i,
   input  wire logic hold_i,
   // State
   output logic      flag_o
);

   logic flag_q;

   // Flag register: hold_i blocks a clear while the fault persists
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flag_q <= 1'b0;
      end else if (set_i) begin
         flag_q <= 1'b1;
      end else if (clear_i && !hold_i) begin
         flag_q <= 1'b0;
      end
   end

   assign flag_o = flag_q;

endmodule : sticky_flag

// ==== fault_status_chk.sv ====
`timescale 1ns/1ns
// Flag timing and clear rules seen at the block ports
module fault_status_chk (
   input wire logic       clk_i, nrst_i, reg_wr_i,
   input wire logic [7:0] reg_addr_i, reg_wdata_i,
   input wire logic       runtime_check_enable_i, thermal_shutdown_enable_i,
   input wire logic       packet_check_enable_i, require_packet_code_i,
   input wire logic       crc_mismatch_i, packet_code_mismatch_i,
   input wire logic       packet_code_missing_i, double_error_i,
   input wire logic       irq_pin_fault_i, thermal_shutdown_i, failsafe_o,
   input wire logic [7:0] control_comm_fault_status_o,
   input wire logic [7:0] test_config_load_fault_status_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Status images and per-register clear masks
   wire [7:0] c = control_comm_fault_status_o;
   wire [7:0] t = test_config_load_fault_status_o;
   wire [7:0] wc = (reg_wr_i && reg_addr_i == 8'h22) ? reg_wdata_i : 8'h00;
   wire [7:0] wt = (reg_wr_i && reg_addr_i == 8'h23) ? reg_wdata_i : 8'h00;
   AST_CRC_SET:
   assert property (crc_mismatch_i && runtime_check_enable_i |-> ##2 c[4])
      else $error("crc flag not set");
   AST_CRC_CAUSE:
   assert property ($rose(c[4]) |->
      $past(crc_mismatch_i && runtime_check_enable_i, 2))
      else $error("crc flag set without enabled mismatch");
   AST_IRQ_SET:
   assert property (irq_pin_fault_i [*6] |-> c[3])
      else $error("pin fault flag not set");
   AST_THERM_SET:
   assert property ((thermal_shutdown_i && thermal_shutdown_enable_i) [*6]
      |-> c[2]) else $error("thermal flag not set");
   AST_PKT_SET:
   assert property (packet_check_enable_i && (packet_code_mismatch_i ||
      require_packet_code_i && packet_code_missing_i) |-> ##2 c[0])
      else $error("packet flag not set");
   AST_DED_SET:
   assert property (double_error_i |-> ##2 (t[2] && failsafe_o))
      else $error("double error flag or failsafe missing");
   AST_CTL_CLR:
   assert property (($past(c) & ~c & ~$past(wc, 2)) == 8'h00)
      else $error("control flag dropped without write of one");
   AST_TST_CLR:
   assert property (($past(t) & ~t & ~$past(wt, 2)) == 8'h00)
      else $error("test flag dropped without write of one");
   AST_IRQ_HOLD:
   assert property ($fell(c[3]) |-> !$past(irq_pin_fault_i, 4))
      else $error("pin fault flag cleared while fault present");
   AST_THERM_HOLD:
   assert property ($fell(c[2]) |-> !$past(thermal_shutdown_i, 4))
      else $error("thermal flag cleared while fault present");
   AST_RSVD:
   assert property ((c & 8'he2) == 8'h00 && (t & 8'hf0) == 8'h00)
      else $error("reserved status bit set");
endmodule : fault_status_chk

bind supervisor_fault_status_flags fault_status_chk status_chk (.*);

// ==== host_model.sv ====
`timescale 1ns/1ns
// Host issuing single-byte register reads and writes
module host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output logic            wr_o, rd_o,
   output logic      [7:0] addr_o, wdata_o
);
   // One strobe cycle, then qualifiers scrambled so stale values never pass
   task put(input logic w, r, input logic [7:0] a, d);
      @(posedge clk_i);
      #1 {wr_o, rd_o, addr_o, wdata_o} = {w, r, a, d};
      @(posedge clk_i);
      #1 {wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
   endtask : put
   // Ones acknowledge flags, zeros leave them
   task wr(input logic [7:0] a, d);
      put(1'b1, 1'b0, a, d);
   endtask : wr
   // Read data is taken once it has settled
   task rd(input logic [7:0] a, output logic [7:0] q);
      put(1'b0, 1'b1, a, ~a);
      @(posedge clk_i);
      #1 q = rdata_i;
   endtask : rd
   initial {wr_o, rd_o, addr_o, wdata_o} = 18'h00000;
endmodule : host_model

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench;
   import fault_status_pkg::*;
   logic       clk, nrst, wr, rd, fs, efs;
   logic [6:0] en, ev;
   logic [1:0] lv;
   logic [7:0] addr, wd, rdat, ctl, tst, ec, et, q, w;
   logic [7:0] ad [3] = '{8'h22, 8'h23, 8'h24};
   int         mismatches, n_checks, cyc = 0;
   supervisor_fault_status_flags uut (
      .clk_i(clk), .nrst_i(nrst), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
      .runtime_check_enable_i(en[0]), .thermal_shutdown_enable_i(en[1]),
      .packet_check_enable_i(en[2]), .single_error_enable_i(en[3]),
      .self_test_done_enable_i(en[4]), .self_test_fail_enable_i(en[5]),
      .require_packet_code_i(en[6]), .crc_mismatch_i(ev[0]),
      .packet_code_mismatch_i(ev[1]), .packet_code_missing_i(ev[2]),
      .single_error_i(ev[3]), .double_error_i(ev[4]),
      .self_test_done_i(ev[5]), .self_test_fail_i(ev[6]),
      .irq_pin_fault_i(lv[1]), .thermal_shutdown_i(lv[0]),
      .control_comm_fault_status_o(ctl), .failsafe_o(fs),
      .test_config_load_fault_status_o(tst));
   host_model h (.clk_i(clk), .rdata_i(rdat), .wr_o(wr), .rd_o(rd),
      .addr_o(addr), .wdata_o(wd));
   // Flags expected from one event pulse under the given enables
   function logic [7:0] fc(logic [6:0] e, logic [6:0] v);
      return {3'h0, v[0] & e[0], 3'h0, e[2] & (v[1] | (e[6] & v[2]))};
   endfunction : fc
   function logic [7:0] ft(logic [6:0] e, logic [6:0] v);
      return {4'h0, v[3] & e[3], v[4], v[5] & e[4], v[6] & e[5]};
   endfunction : ft
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task chk(input logic [7:0] g, e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task end_sim();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   // Level fault: set, clear refused, sticky after removal, then cleared
   task lvl(input int b);
      en = 7'h02;
      lv[b - 2] = 1'b1;
      tick(8);
      chk(ctl, 8'h01 << b);
      h.wr(8'h22, 8'h01 << b);
      tick(3);
      chk(ctl, 8'h01 << b);
      lv = 2'b00;
      tick(6);
      chk(ctl, 8'h01 << b);
      h.wr(8'h22, 8'h01 << b);
      tick(3);
      chk(ctl, 8'h00);
      $display("test level %0d done", b);
   endtask : lvl
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Cuts a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         mismatches++;
         end_sim();
      end
   end
   initial begin
      {nrst, en, ev, lv, ec, et, efs} = 34'h0;
      mismatches = 0;
      n_checks = 0;
      void'($urandom(2));
      tick(3);
      nrst = 1'b1;
      chk(ctl | tst, STATUS_RESET);
      lvl(3);
      lvl(2);
      // First two passes: all events with enables off, then all on
      for (int i = 0; i < 40; i++) begin
         en = (i < 2) ? {7{i[0]}} : 7'($urandom);
         ev = (i < 2) ? 7'h7f : 7'($urandom);
         {ec, et, efs} = {ec | fc(en, ev), et | ft(en, ev), efs | ev[4]};
         tick(1);
         ev = 7'h00;
         tick(2);
         chk(ctl, ec);
         chk(tst, et);
         chk({7'h00, fs}, {7'h00, efs});
         foreach (ad[k]) begin
            w = 8'($urandom);
            h.wr(ad[k], w);
            ec = (k == 0) ? ec & ~w : ec;
            et = (k == 1) ? et & ~w : et;
            h.rd(ad[k], q);
            chk(q, (k == 0) ? ec : (k == 1) ? et : 8'h00);
         end
      end
      $display("test random done");
      // Mid-run reset clears flags and failsafe, then a double error sets its flag and failsafe again
      nrst = 1'b0;
      tick(2);
      chk(ctl | tst, STATUS_RESET);
      chk({7'h00, fs}, 8'h00);
      nrst = 1'b1;
      ev = 7'h10;
      tick(1);
      ev = 7'h00;
      tick(2);
      chk(tst, 8'h04);
      chk({7'h00, fs}, 8'h01);
      $display("test reset done");
      end_sim();
   end
endmodule : testbench
